// ===== rtl/gord_fifo.sv
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ns
module gord_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_sync_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import gord_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } gord_fifo_state_type;

    gord_fifo_state_type st;
    gord_fifo_state_type next_st;
    logic do_write;
    logic do_read;

    // pointer step with wrap, depth need not be a power of two
    function automatic logic [PW-1:0] step_ptr(input logic [PW-1:0] p);
        step_ptr = (p == LAST) ? '0 : PW'(p + 1'b1);
    endfunction : step_ptr

    // honest flags straight from the occupancy count
    assign in_ready = (st.count != FULL);
    assign out_valid = (st.count != '0);
    assign out_data = st.mem[st.rd_ptr];
    assign do_write = in_valid && in_ready;
    assign do_read = out_valid && out_ready;

    // next-state for storage, pointers and count
    always_comb begin
        next_st = st;
        if (do_write) begin
            next_st.mem[st.wr_ptr] = in_data;
            next_st.wr_ptr = step_ptr(st.wr_ptr);
        end
        if (do_read) begin
            next_st.rd_ptr = step_ptr(st.rd_ptr);
        end
        if (do_write && !do_read) begin
            next_st.count = CW'(st.count + 1'b1);
        end else if (do_read && !do_write) begin
            next_st.count = CW'(st.count - 1'b1);
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : gord_fifo

// ===== rtl/gord_pkg.sv
// constants, types and helpers for the rate trim and output divider block
// What this block does
// - three signed 16-bit trims, high/low byte registers
// - trim added to raw sample before output
// - output rate is internal rate over divider+1
// - divided path runs from 1 kHz internal rate
// - divider only with bypass 00, setting 1..6
// - divided strobe paces outputs and buffer writes
// - filter setting used only when bypass is 00
package gord_pkg;

    // register port map
    localparam logic [7:0] GORD_ADDR_TRIM_FIRST = 8'h13;
    localparam logic [7:0] GORD_ADDR_X_HIGH = 8'h13;
    localparam logic [7:0] GORD_ADDR_X_LOW = 8'h14;
    localparam logic [7:0] GORD_ADDR_Y_HIGH = 8'h15;
    localparam logic [7:0] GORD_ADDR_Y_LOW = 8'h16;
    localparam logic [7:0] GORD_ADDR_Z_HIGH = 8'h17;
    localparam logic [7:0] GORD_ADDR_Z_LOW = 8'h18;
    localparam logic [7:0] GORD_ADDR_DIVIDER = 8'h19;
    localparam logic [7:0] GORD_READ_UNMAPPED = 8'h00;

    // reset values
    localparam logic [7:0] GORD_TRIM_RESET = 8'h00;
    localparam logic [7:0] GORD_DIVIDER_RESET = 8'h00;

    // filter selection codes
    localparam logic [1:0] GORD_BYPASS_NONE = 2'b00;
    localparam logic [2:0] GORD_SETTING_LOW = 3'h0;
    localparam logic [2:0] GORD_SETTING_HIGH = 3'h7;

    // timing
    localparam int GORD_CLK_HZ = 25000000;
    localparam int GORD_INTERNAL_RATE_HZ = 1000;
    localparam int GORD_INTERNAL_PERIOD_CYCLES = GORD_CLK_HZ / GORD_INTERNAL_RATE_HZ;

    // data shapes
    localparam int GORD_SAMPLE_W = 16;
    localparam int GORD_AXES = 3;
    localparam int GORD_FRAME_W = GORD_SAMPLE_W * GORD_AXES;
    localparam int GORD_FIFO_DEPTH = 8;
    localparam int GORD_TRIM_BYTES = 6;

    // sample pipeline steps, gray along wait-add-push
    typedef enum logic [1:0] {
        GORD_ST_WAIT = 2'b00,
        GORD_ST_ADD = 2'b01,
        GORD_ST_PUSH = 2'b11
    } gord_step_type;

    // divider applies only for the 1 kHz filter settings
    function automatic logic gord_divider_effective(input logic [1:0] bypass, input logic [2:0] setting);
        gord_divider_effective = (bypass == GORD_BYPASS_NONE) && (setting > GORD_SETTING_LOW)
            && (setting < GORD_SETTING_HIGH);
    endfunction : gord_divider_effective

    // signed add, clamped so a large trim cannot wrap the sign
    function automatic logic [15:0] gord_trim_add(input logic [15:0] raw, input logic [15:0] trim);
        logic signed [16:0] sum;
        sum = 17'($signed(raw)) + 17'($signed(trim));
        if (sum[16] != sum[15]) begin
            gord_trim_add = sum[16] ? 16'h8000 : 16'h7fff;
        end else begin
            gord_trim_add = sum[15:0];
        end
    endfunction : gord_trim_add

endpackage : gord_pkg

// ===== rtl/gord_top.sv
// rate bias trim, output rate divider and sample buffer
`timescale 1ns/1ns
module gord_top #(
    parameter logic [15:0] INTERNAL_PERIOD_CYCLES = 16'(gord_pkg::GORD_INTERNAL_PERIOD_CYCLES)
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] filter_bypass_select,
    input wire logic [2:0] lowpass_setting,
    input wire logic raw_valid,
    input wire logic [gord_pkg::GORD_SAMPLE_W-1:0] raw_x,
    input wire logic [gord_pkg::GORD_SAMPLE_W-1:0] raw_y,
    input wire logic [gord_pkg::GORD_SAMPLE_W-1:0] raw_z,
    output logic [gord_pkg::GORD_SAMPLE_W-1:0] rate_x,
    output logic [gord_pkg::GORD_SAMPLE_W-1:0] rate_y,
    output logic [gord_pkg::GORD_SAMPLE_W-1:0] rate_z,
    output logic rate_update,
    output logic divider_active,
    output logic fifo_fill_ready,
    output logic fifo_overflow,
    input wire logic overflow_clear,
    output logic fifo_out_valid,
    input wire logic fifo_out_ready,
    output logic [gord_pkg::GORD_FRAME_W-1:0] fifo_out_data
);
    import gord_pkg::*;

    localparam logic [15:0] PERIOD_LAST = 16'(INTERNAL_PERIOD_CYCLES - 16'h0001);

    typedef struct packed {
        logic [GORD_TRIM_BYTES-1:0][7:0] trim;
        logic [7:0] divider;
        logic [7:0] rdata;
        logic [15:0] tick_count;
        logic [7:0] div_count;
        logic [GORD_SAMPLE_W-1:0] hold_x;
        logic [GORD_SAMPLE_W-1:0] hold_y;
        logic [GORD_SAMPLE_W-1:0] hold_z;
        logic [GORD_SAMPLE_W-1:0] rate_x;
        logic [GORD_SAMPLE_W-1:0] rate_y;
        logic [GORD_SAMPLE_W-1:0] rate_z;
        logic rate_update;
        gord_step_type step;
        logic overflow;
    } gord_state_type;

    gord_state_type st;
    gord_state_type next_st;

    logic rst_meta_b;
    logic rst_sync_b;
    logic trim_hit;
    logic [7:0] trim_index;
    logic internal_tick;
    logic sample_due;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [GORD_FRAME_W-1:0] fifo_in_data;
    logic [15:0] trim_x;
    logic [15:0] trim_y;
    logic [15:0] trim_z;

    // reset release through two flops; assert stays asynchronous
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // address decode for the trim byte window
    assign trim_hit = (reg_addr >= GORD_ADDR_X_HIGH) && (reg_addr <= GORD_ADDR_Z_LOW);
    assign trim_index = 8'(reg_addr - GORD_ADDR_TRIM_FIRST);

    // byte pairs joined into signed trims, high byte first in the map
    assign trim_x = {st.trim[GORD_ADDR_X_HIGH - GORD_ADDR_TRIM_FIRST],
                     st.trim[GORD_ADDR_X_LOW - GORD_ADDR_TRIM_FIRST]};
    assign trim_y = {st.trim[GORD_ADDR_Y_HIGH - GORD_ADDR_TRIM_FIRST],
                     st.trim[GORD_ADDR_Y_LOW - GORD_ADDR_TRIM_FIRST]};
    assign trim_z = {st.trim[GORD_ADDR_Z_HIGH - GORD_ADDR_TRIM_FIRST],
                     st.trim[GORD_ADDR_Z_LOW - GORD_ADDR_TRIM_FIRST]};

    // divider only counts for the 1 kHz filter settings
    assign divider_active = gord_divider_effective(filter_bypass_select, lowpass_setting);

    // local 1 kHz tick, the dividend of the output divider
    assign internal_tick = divider_active && (st.tick_count == PERIOD_LAST);

    // when dividing, every divider+1 ticks; else each filter sample
    always_comb begin
        if (divider_active) begin
            sample_due = internal_tick && (st.div_count == st.divider);
        end else begin
            sample_due = raw_valid;
        end
    end

    // buffer write request while in the push step
    assign fifo_in_valid = (st.step == GORD_ST_PUSH);
    assign fifo_in_data = {st.rate_x, st.rate_y, st.rate_z};

    // next-state for registers, divider and sample pipeline
    always_comb begin
        next_st = st;
        next_st.rate_update = 1'b0;

        // register writes; unmapped addresses are ignored
        if (reg_write) begin
            if (trim_hit) begin
                next_st.trim[trim_index[2:0]] = reg_wdata;
            end else if (reg_addr == GORD_ADDR_DIVIDER) begin
                next_st.divider = reg_wdata;
            end
        end

        // read data is captured, so it is stable for the host
        if (reg_read) begin
            if (trim_hit) begin
                next_st.rdata = st.trim[trim_index[2:0]];
            end else if (reg_addr == GORD_ADDR_DIVIDER) begin
                next_st.rdata = st.divider;
            end else begin
                next_st.rdata = GORD_READ_UNMAPPED;
            end
        end

        // tick and divide counters park at zero when not dividing
        if (!divider_active) begin
            next_st.tick_count = '0;
            next_st.div_count = '0;
        end else if (internal_tick) begin
            next_st.tick_count = '0;
            if (st.div_count == st.divider) begin
                next_st.div_count = '0;
            end else begin
                next_st.div_count = 8'(st.div_count + 8'h01);
            end
        end else begin
            next_st.tick_count = 16'(st.tick_count + 16'h0001);
        end

        // newest filter sample is held for the divided strobe
        if (raw_valid) begin
            next_st.hold_x = raw_x;
            next_st.hold_y = raw_y;
            next_st.hold_z = raw_z;
        end

        // a strobe outside wait is dropped; samples need 3-cycle spacing
        unique case (st.step)
            GORD_ST_WAIT: begin
                if (sample_due) begin
                    next_st.step = GORD_ST_ADD;
                end
            end
            GORD_ST_ADD: begin
                next_st.rate_x = gord_trim_add(st.hold_x, trim_x);
                next_st.rate_y = gord_trim_add(st.hold_y, trim_y);
                next_st.rate_z = gord_trim_add(st.hold_z, trim_z);
                next_st.rate_update = 1'b1;
                next_st.step = GORD_ST_PUSH;
            end
            GORD_ST_PUSH: begin
                // sample cannot wait, so a full buffer loses it
                if (!fifo_in_ready) begin
                    next_st.overflow = 1'b1;
                end
                next_st.step = GORD_ST_WAIT;
            end
            default: begin
                next_st.step = GORD_ST_WAIT;
            end
        endcase

        // clear loses against a same-cycle overflow
        if (overflow_clear && !(fifo_in_valid && !fifo_in_ready)) begin
            next_st.overflow = 1'b0;
        end
    end

    // state register, trims and divider reset to zero
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st <= '0;
            st.trim <= {GORD_TRIM_BYTES{GORD_TRIM_RESET}};
            st.divider <= GORD_DIVIDER_RESET;
            st.step <= GORD_ST_WAIT;
        end else begin
            st <= next_st;
        end
    end

    // sample buffer toward the host
    gord_fifo #(
        .WIDTH(GORD_FRAME_W),
        .DEPTH(GORD_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_sync_b(rst_sync_b),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // outputs straight from flops, except fill ready decoded from the buffer count
    assign reg_rdata = st.rdata;
    assign rate_x = st.rate_x;
    assign rate_y = st.rate_y;
    assign rate_z = st.rate_z;
    assign rate_update = st.rate_update;
    assign fifo_overflow = st.overflow;
    assign fifo_fill_ready = fifo_in_ready;

endmodule : gord_top

// ===== verification/gord_drain.sv
// buffer reader standing in for the host, prompt, slow or stalled
`timescale 1ns/1ns
module gord_drain (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stall,
    input wire logic slow,
    output logic ready
);
    logic [1:0] phase;
    // slow mode takes one word in four, like a burst reader between bursts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 2'h0;
            ready <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            ready <= !stall && (!slow || phase == 2'h0);
        end
    end
endmodule : gord_drain

// ===== verification/gord_props.sv
// port assertions for the rate trim, divider and buffer block
`timescale 1ns/1ns
module gord_props #(
    parameter logic [15:0] INTERNAL_PERIOD_CYCLES = 16'h0010
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] filter_bypass_select,
    input wire logic [2:0] lowpass_setting,
    input wire logic raw_valid,
    input wire logic [15:0] raw_x,
    input wire logic [15:0] raw_y,
    input wire logic [15:0] raw_z,
    input wire logic [15:0] rate_x,
    input wire logic [15:0] rate_y,
    input wire logic [15:0] rate_z,
    input wire logic rate_update,
    input wire logic divider_active,
    input wire logic fifo_fill_ready,
    input wire logic fifo_overflow,
    input wire logic overflow_clear,
    input wire logic fifo_out_valid,
    input wire logic fifo_out_ready,
    input wire logic [47:0] fifo_out_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [15:0] dcnt;
    // cycles spent dividing, saturating so a long run cannot wrap
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) dcnt <= 16'h0000;
        else if (!divider_active) dcnt <= 16'h0000;
        else if (dcnt != 16'hffff) dcnt <= dcnt + 16'h0001;
    end
    chk_div_decode: assert property (divider_active == (filter_bypass_select == 2'b00 && lowpass_setting > 3'h0
        && lowpass_setting < 3'h7)) else $error("divider enable decode wrong");
    chk_raw_latency: assert property (raw_valid && !divider_active && !$past(divider_active)
        && !$past(divider_active, 2) && !$past(raw_valid) && !$past(raw_valid, 2) |-> ##2 rate_update)
        else $error("undivided sample not passed on in two cycles");
    chk_update_pulse: assert property (rate_update |=> !rate_update) else $error("update strobe too long");
    chk_rate_cause: assert property ($changed({rate_x, rate_y, rate_z}) |-> rate_update)
        else $error("rate output changed without update");
    chk_buffer_write: assert property (rate_update && fifo_fill_ready |=> fifo_out_valid)
        else $error("update not written to buffer");
    chk_full_drop: assert property (rate_update && !fifo_fill_ready |=> fifo_overflow)
        else $error("drop on full buffer not flagged");
    chk_overflow_sticky: assert property (fifo_overflow && !overflow_clear |=> fifo_overflow)
        else $error("overflow flag lost");
    chk_unmapped_read: assert property (reg_read && (reg_addr < 8'h13 || reg_addr > 8'h19) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata)) else $error("read data moved");
    chk_div_spacing: assert property (rate_update && dcnt > 16'h0002 |-> dcnt >= INTERNAL_PERIOD_CYCLES)
        else $error("divided update before one tick");
    cover property (rate_update && divider_active);
    cover property (rate_update && !fifo_fill_ready);
    cover property (reg_read ##1 reg_rdata != 8'h00);
endmodule : gord_props

// ===== verification/gord_top_test.sv
// self-checking bench for the rate trim, divider and buffer block
`timescale 1ns/1ns
`define CHK(g, e) chk(48'(g), 48'(e))
module gord_top_test;
    import gord_pkg::*;
    localparam logic [15:0] PERIOD = 16'h0010; // short tick keeps the run brief
    logic clk = 0, rst_b = 0, reg_write = 0, reg_read = 0, raw_valid = 0, overflow_clear = 0;
    logic stall = 0, slow = 0, rd_seen = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [1:0] filter_bypass_select = 2'b01;
    logic [2:0] lowpass_setting = 3'h0;
    logic [15:0] raw_x = 16'h0000, raw_y = 16'h0000, raw_z = 16'h0000, rate_x, rate_y, rate_z;
    logic rate_update, divider_active, fifo_fill_ready, fifo_overflow, fifo_out_valid, fifo_out_ready;
    logic [47:0] fifo_out_data;
    logic [15:0] trim [3] = '{16'h7fff, 16'h0000, 16'h0000};
    logic [31:0] seed = 32'd86982;
    logic [7:0] rq [$];
    logic [47:0] sq [$], fq [$];
    int err_count = 0, n_compared = 0, n;

    always #20 clk = ~clk;

    gord_top #(.INTERNAL_PERIOD_CYCLES(PERIOD)) uut (.clk, .rst_b, .reg_addr, .reg_write, .reg_wdata, .reg_read,
        .reg_rdata, .filter_bypass_select, .lowpass_setting, .raw_valid, .raw_x, .raw_y, .raw_z, .rate_x, .rate_y,
        .rate_z, .rate_update, .divider_active, .fifo_fill_ready, .fifo_overflow, .overflow_clear, .fifo_out_valid,
        .fifo_out_ready, .fifo_out_data);
    gord_drain reader (.clk, .rst_b, .stall, .slow, .ready(fifo_out_ready));

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // clamped signed sum, so a large trim never wraps the sign
    function automatic logic [15:0] sat(logic [15:0] a, logic [15:0] b);
        logic [16:0] s;
        s = {a[15], a} + {b[15], b};
        return (s[16] != s[15]) ? (s[16] ? 16'h8000 : 16'h7fff) : s[15:0];
    endfunction : sat
    task automatic rnd(output logic [15:0] v);
        repeat (16) seed = lfsr(seed);
        v = seed[15:0];
    endtask : rnd
    task automatic chk(logic [47:0] g, logic [47:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic results();
        $display("compared %0d, mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    // one register cycle; strobes are held so accesses can run back to back
    task automatic acc(logic w, logic r, logic [7:0] a, logic [7:0] d);
        if (r) rq.push_back(d);
        reg_write <= w;
        reg_read <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask : acc
    // one random filter sample, spaced wider than the pipeline
    task automatic smp(logic keep);
        logic [15:0] r [3];
        foreach (r[i]) rnd(r[i]);
        sq.push_back({sat(r[0], trim[0]), sat(r[1], trim[1]), sat(r[2], trim[2])});
        if (keep) fq.push_back(sq[$]);
        raw_x <= r[0];
        raw_y <= r[1];
        raw_z <= r[2];
        raw_valid <= 1'b1;
        @(posedge clk);
        raw_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : smp
    task automatic wupd();
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!rate_update && n < 500);
    endtask : wupd
    task automatic idle();
        for (int i = 0; i < 400 && fq.size() > 0; i++) @(posedge clk);
        `CHK(fq.size(), 0);
    endtask : idle

    // takes the oldest note off each queue as its result shows
    always @(posedge clk) begin
        rd_seen <= reg_read;
        if (rd_seen) `CHK(reg_rdata, rq.pop_front());
        if (rate_update) `CHK({rate_x, rate_y, rate_z}, sq.pop_front());
        if (fifo_out_valid && fifo_out_ready) `CHK(fifo_out_data, fq.pop_front());
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values, with unmapped places either side of the map
        for (int a = 8'h12; a <= 8'h1a; a++) acc(0, 1, 8'(a), 8'h00);
        rnd(trim[1]);
        rnd(trim[2]);
        // write pass then read-back pass, a refused write among them
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 6; i++) begin
                acc(p == 0, p == 1, GORD_ADDR_TRIM_FIRST + 8'(i), i % 2 ? trim[i / 2][7:0] : trim[i / 2][15:8]);
            end
            acc(p == 0, p == 1, GORD_ADDR_DIVIDER, 8'h02);
            acc(p == 0, p == 1, 8'h1a, p ? 8'h00 : 8'h5a);
        end
        acc(0, 0, 8'h00, 8'h00);
        $display("register test done");
        // every bypass and setting code, samples only where undivided
        slow <= 1'b1;
        for (int c = 0; c < 32; c++) begin
            {filter_bypass_select, lowpass_setting} <= 5'(c);
            @(posedge clk);
            `CHK(divider_active, c > 0 && c < 7);
            if (!(c > 0 && c < 7)) smp(1);
        end
        idle();
        $display("undivided path test done");
        // reader stalls: eight kept, two lost and flagged
        stall <= 1'b1;
        slow <= 1'b0;
        for (int i = 0; i < 10; i++) smp(i < 8);
        `CHK({fifo_overflow, fifo_fill_ready}, 2'b10);
        overflow_clear <= 1'b1;
        stall <= 1'b0;
        @(posedge clk);
        overflow_clear <= 1'b0;
        idle();
        `CHK(fifo_overflow, 1'b0);
        $display("buffer full test done");
        // divided path repeats the held sample every three ticks
        filter_bypass_select <= 2'b00;
        lowpass_setting <= 3'h3;
        smp(1);
        sq.push_back(sq[$]);
        fq.push_back(fq[$]);
        wupd();
        wupd();
        `CHK(n, 3 * PERIOD);
        filter_bypass_select <= 2'b01;
        idle();
        `CHK(sq.size(), 0);
        $display("divided path test done");
        results();
    end

    // cut a hang short; the tests need under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        results();
    end
endmodule : gord_top_test

bind gord_top gord_props #(.INTERNAL_PERIOD_CYCLES(INTERNAL_PERIOD_CYCLES)) props_i (.clk, .rst_b, .reg_addr,
    .reg_write, .reg_wdata, .reg_read, .reg_rdata, .filter_bypass_select, .lowpass_setting, .raw_valid, .raw_x,
    .raw_y, .raw_z, .rate_x, .rate_y, .rate_z, .rate_update, .divider_active, .fifo_fill_ready, .fifo_overflow,
    .overflow_clear, .fifo_out_valid, .fifo_out_ready, .fifo_out_data);
